// *** verilog/ospc_pkg.sv ***
// constants and types for the OTP and sector protection command block
// assumes one system clock of 25 MHz that oversamples the serial clock
package ospc_pkg;
   localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] CMD_OTP_PROGRAM = 8'h42;
   localparam logic [7:0] CMD_OTP_READ = 8'h4b;
   localparam logic [7:0] CMD_PCFG_READ = 8'h2b;
   localparam logic [7:0] CMD_PCFG_PROGRAM = 8'h2f;
   localparam logic [7:0] CMD_DYN_READ = 8'hfa;
   localparam logic [7:0] CMD_DYN_READ_WIDE = 8'he0;
   localparam logic [7:0] CMD_DYN_WRITE = 8'hfb;
   localparam logic [7:0] CMD_DYN_WRITE_WIDE = 8'he1;
   localparam logic [7:0] DYN_PROTECT = 8'h00;
   localparam logic [7:0] DYN_UNPROTECT = 8'hff;
   localparam logic [7:0] BYTE_ONES = 8'hff;
   localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
   localparam logic [5:0] ADDR_BITS_WIDE = 6'h20;
   localparam logic [4:0] BITS_ONE_BYTE = 5'h08;
   localparam logic [4:0] BITS_TWO_BYTES = 5'h10;
   localparam logic [4:0] BITS_SAT = 5'h18;
   localparam int OTP_BYTES = 2048;
   localparam int OTP_AW = 11;
   localparam int LOCK_REGIONS = 4;
   localparam int REGION_LSB = 9;
   localparam int UNIT_LSB = 4;
   localparam int ECC_UNITS = 128;
   localparam int SECTORS = 256;
   localparam int SECTOR_LSB = 19;
   localparam int SECTOR_W = 8;
   localparam logic [15:0] PCFG_RESET = 16'hffff;
   localparam logic DYN_RESET = 1'b0;
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_W = 19;
   localparam int CLK_PERIOD_NS = 40;
   localparam int PROG_TIME_NS = 2000;
   localparam int OTP_BYTE_NS = 200;
   // least times, rounded up to whole cycles
   localparam logic [7:0] PROG_CYC =
      8'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] OTP_BYTE_CYC =
      8'((OTP_BYTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   typedef enum logic [2:0]
   {
      ST_CMD = 3'h0,
      ST_ADDR = 3'h1,
      ST_DUMMY = 3'h3,
      ST_DOUT = 3'h2,
      ST_DIN = 3'h6,
      ST_SKIP = 3'h7
   } ospc_frame_t;
   typedef enum logic [1:0]
   {
      ENG_IDLE = 2'h0,
      ENG_OTP = 2'h1,
      ENG_WAIT = 2'h3
   } ospc_eng_t;
endpackage : ospc_pkg

// *** verilog/ospc_stream_if.sv ***
// valid/ready word stream between the command decoder and its buffer
// assumes both ends on the same clock
`timescale 1ns/10ps
`default_nettype none
interface ospc_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport sink (input valid, input data, output ready);
   modport source (output valid, output data, input ready);
endinterface : ospc_stream_if
`default_nettype wire

// *** verilog/ospc_fifo.sv ***
// small synchronous FIFO with valid/ready on both sides
// assumes depth is a power of two; one clock, synchronous reset
`timescale 1ns/10ps
`default_nettype none
module ospc_fifo #(parameter int W = 8, parameter int D = 4)
(
   input wire logic clk_in,
   input wire logic rst_in,
   ospc_stream_if.sink fill,
   ospc_stream_if.source drain
);
   localparam int PW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [PW:0] wr_ptr;
   logic [PW:0] rd_ptr;
   logic full;
   logic empty;

   ////////////////////////////////////////////////////////////////////
   // extra pointer bit tells full from empty
   assign full = (wr_ptr[PW] != rd_ptr[PW]) &&
      (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
   assign empty = (wr_ptr == rd_ptr);
   assign fill.ready = ~full;
   assign drain.valid = ~empty;
   assign drain.data = mem[rd_ptr[PW-1:0]];

   // pointers
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (fill.valid && !full)
            wr_ptr <= wr_ptr + {{PW{1'b0}}, 1'b1};
         if (drain.ready && !empty)
            rd_ptr <= rd_ptr + {{PW{1'b0}}, 1'b1};
      end
   end

   // storage, no reset needed: empty hides stale words
   always_ff @(posedge clk_in)
   begin
      if (fill.valid && !full)
         mem[wr_ptr[PW-1:0]] <= fill.data;
   end
endmodule : ospc_fifo
`default_nettype wire

// *** verilog/ospc_cmd.sv ***
// serial command decoder for OTP access and sector protection
// assumes serial pins asynchronous to clk_in and oversampled 8x or more;
// config inputs come from logic on clk_in
`timescale 1ns/10ps
`default_nettype none
module ospc_cmd
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic cs_n_in,
   input wire logic sck_in,
   input wire logic [7:0] io_in,
   output logic [7:0] io_out,
   output logic [7:0] io_oe_n_out,
   input wire logic four_lane_command_mode_in,
   input wire logic addr_wide_in,
   input wire logic [3:0] read_latency_in,
   input wire logic [ospc_pkg::LOCK_REGIONS-1:0] otp_region_lock_in,
   output logic op_in_progress_flag_out,
   output logic program_error_out,
   output logic write_enable_latch_out,
   output logic [15:0] protection_configuration_out,
   output logic otp_ecc_off_out
);
   logic [1:0] cs_sync;
   logic [1:0] sck_sync;
   logic [7:0] io_meta;
   logic [7:0] io_s;
   logic cs_n;
   logic cs_d;
   logic sck_d;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic quad;
   logic [2:0] step;
   logic [7:0] next_sh;
   logic [31:0] next_addr;
   logic byte_done;
   logic addr_done;
   ospc_pkg::ospc_frame_t state;
   logic [7:0] sh;
   logic [7:0] opcode;
   logic [3:0] bitcnt;
   logic [5:0] abits;
   logic [5:0] alen;
   logic [31:0] addr;
   logic [3:0] dummy;
   logic [4:0] din_bits;
   logic [15:0] pcfg_new;
   logic [7:0] dyn_new;
   logic [10:0] wr_off;
   logic [7:0] dout_sh;
   logic [3:0] obit;
   logic [11:0] rd_ptr;
   logic [11:0] ptr;
   logic hi_sel;
   logic driving;
   logic [7:0] src_byte;
   logic [ospc_pkg::SECTOR_W-1:0] sector;
   ospc_pkg::ospc_eng_t eng;
   logic [7:0] tmr;
   logic write_enable_latch;
   logic perr;
   logic ovf;
   logic [15:0] pcfg;
   logic [7:0] otp_mem [ospc_pkg::OTP_BYTES];
   logic [ospc_pkg::SECTORS-1:0] dyn_lock;
   logic [ospc_pkg::ECC_UNITS-1:0] unit_prog;
   logic [ospc_pkg::ECC_UNITS-1:0] unit_touch;
   logic [ospc_pkg::ECC_UNITS-1:0] ecc_off;
   logic [10:0] pop_addr;
   logic [7:0] pop_byte;
   logic pop_fire;
   logic push_req;
   logic zeros;
   logic locked_zero;
   logic [6:0] unit;
   logic [6:0] rd_unit;
   logic idle_wel;

   ospc_stream_if #(.W(ospc_pkg::FIFO_W)) push_if ();
   ospc_stream_if #(.W(ospc_pkg::FIFO_W)) pop_if ();

   ospc_fifo #(.W(ospc_pkg::FIFO_W), .D(ospc_pkg::FIFO_DEPTH)) u_fifo
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .fill(push_if.sink),
      .drain(pop_if.source)
   );

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers, data kept in step with the clock pin
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         cs_sync <= 2'h3;
         sck_sync <= 2'h0;
         io_meta <= 8'h00;
         io_s <= 8'h00;
         cs_d <= 1'b1;
         sck_d <= 1'b0;
      end
      else
      begin
         cs_sync <= {cs_sync[0], cs_n_in};
         sck_sync <= {sck_sync[0], sck_in};
         io_meta <= io_in;
         io_s <= io_meta;
         cs_d <= cs_sync[1];
         sck_d <= sck_sync[1];
      end
   end

   // edge strobes in the system clock
   assign cs_n = cs_sync[1];
   assign sck_rise = sck_sync[1] && !sck_d && !cs_n;
   assign sck_fall = !sck_sync[1] && sck_d && !cs_n;
   assign cs_rise = cs_n && !cs_d;

   // lane width: one bit or a nibble per serial clock
   assign quad = four_lane_command_mode_in;
   assign step = quad ? 3'h4 : 3'h1;
   assign next_sh = quad ? {sh[3:0], io_s[3:0]} : {sh[6:0], io_s[0]};
   assign next_addr = quad ? {addr[27:0], io_s[3:0]} :
      {addr[30:0], io_s[0]};
   assign byte_done = (bitcnt + {1'b0, step}) == 4'h8;
   assign addr_done = (abits + {3'h0, step}) == alen;
   assign sector = addr[ospc_pkg::SECTOR_LSB +: ospc_pkg::SECTOR_W];

   ////////////////////////////////////////////////////////////////////
   // frame decoder, sampled on serial clock rise
   always_ff @(posedge clk_in)
   begin
      if (rst_in || cs_n)
      begin
         state <= ospc_pkg::ST_CMD;
         bitcnt <= 4'h0;
         abits <= 6'h0;
         din_bits <= 5'h0;
         addr <= 32'h0;
         wr_off <= 11'h0;
         if (rst_in)
         begin
            sh <= 8'h00;
            opcode <= 8'h00;
            alen <= ospc_pkg::ADDR_BITS_NARROW;
            dummy <= 4'h0;
            pcfg_new <= 16'h0000;
            dyn_new <= 8'h00;
         end
      end
      else if (sck_rise)
      begin
         case (state)
            ospc_pkg::ST_CMD:
            begin
               sh <= next_sh;
               bitcnt <= byte_done ? 4'h0 : bitcnt + {1'b0, step};
               if (byte_done)
               begin
                  opcode <= next_sh;
                  alen <= addr_wide_in ? ospc_pkg::ADDR_BITS_WIDE :
                     ospc_pkg::ADDR_BITS_NARROW;
                  case (next_sh)
                     ospc_pkg::CMD_OTP_PROGRAM,
                     ospc_pkg::CMD_OTP_READ,
                     ospc_pkg::CMD_DYN_READ,
                     ospc_pkg::CMD_DYN_WRITE:
                        state <= ospc_pkg::ST_ADDR;
                     ospc_pkg::CMD_DYN_READ_WIDE,
                     ospc_pkg::CMD_DYN_WRITE_WIDE:
                     begin
                        alen <= ospc_pkg::ADDR_BITS_WIDE;
                        state <= ospc_pkg::ST_ADDR;
                     end
                     ospc_pkg::CMD_PCFG_READ:
                        state <= ospc_pkg::ST_DOUT;
                     ospc_pkg::CMD_PCFG_PROGRAM:
                        state <= ospc_pkg::ST_DIN;
                     default:
                        state <= ospc_pkg::ST_SKIP;
                  endcase
               end
            end
            ospc_pkg::ST_ADDR:
            begin
               addr <= next_addr;
               abits <= abits + {3'h0, step};
               if (addr_done)
               begin
                  case (opcode)
                     ospc_pkg::CMD_OTP_READ:
                     begin
                        dummy <= read_latency_in;
                        state <= (read_latency_in == 4'h0) ?
                           ospc_pkg::ST_DOUT : ospc_pkg::ST_DUMMY;
                     end
                     ospc_pkg::CMD_DYN_READ,
                     ospc_pkg::CMD_DYN_READ_WIDE:
                        state <= ospc_pkg::ST_DOUT;
                     default:
                        state <= ospc_pkg::ST_DIN;
                  endcase
               end
            end
            ospc_pkg::ST_DUMMY:
            begin
               dummy <= dummy - 4'h1;
               if (dummy == 4'h1)
                  state <= ospc_pkg::ST_DOUT;
            end
            ospc_pkg::ST_DIN:
            begin
               sh <= next_sh;
               bitcnt <= byte_done ? 4'h0 : bitcnt + {1'b0, step};
               if (din_bits < ospc_pkg::BITS_SAT)
                  din_bits <= din_bits + {2'h0, step};
               if (byte_done)
               begin
                  // low byte arrives first
                  if (din_bits < ospc_pkg::BITS_ONE_BYTE)
                     pcfg_new[7:0] <= next_sh;
                  else
                     pcfg_new[15:8] <= next_sh;
                  dyn_new <= next_sh;
                  wr_off <= wr_off + 11'h1;
               end
            end
            ospc_pkg::ST_SKIP:
            begin
               if (din_bits < ospc_pkg::BITS_SAT)
                  din_bits <= din_bits + {2'h0, step};
            end
            default:
               state <= ospc_pkg::ST_SKIP;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // OTP data bytes queue until deselect starts the write
   assign idle_wel = write_enable_latch && (eng == ospc_pkg::ENG_IDLE);
   assign push_req = sck_rise && (state == ospc_pkg::ST_DIN) &&
      byte_done && (opcode == ospc_pkg::CMD_OTP_PROGRAM) && idle_wel;
   assign push_if.valid = push_req;
   // only the low eleven address bits reach the OTP space
   assign push_if.data = {addr[10:0] + wr_off, next_sh};

   // a full buffer refuses the byte; the program reports an error
   always_ff @(posedge clk_in)
   begin
      if (rst_in || (cs_d && !cs_n))
         ovf <= 1'b0;
      else if (push_req && !push_if.ready)
         ovf <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////
   // read source: OTP, protection config or the sector lock byte
   assign ptr = driving ? rd_ptr : {1'b0, addr[10:0]};
   always_comb
   begin
      case (opcode)
         ospc_pkg::CMD_OTP_READ:
            src_byte = ptr[11] ? 8'hff : otp_mem[ptr[10:0]];
         ospc_pkg::CMD_PCFG_READ:
            src_byte = (driving && hi_sel) ? pcfg[15:8] : pcfg[7:0];
         default:
            src_byte = dyn_lock[sector] ? ospc_pkg::DYN_PROTECT :
               ospc_pkg::DYN_UNPROTECT;
      endcase
   end

   // output shifter, new bit (a nibble in four-lane mode) on each serial clock fall
   always_ff @(posedge clk_in)
   begin
      if (rst_in || cs_n)
      begin
         driving <= 1'b0;
         dout_sh <= 8'h00;
         obit <= 4'h0;
         rd_ptr <= 12'h000;
         hi_sel <= 1'b0;
         io_out <= 8'h00;
         io_oe_n_out <= 8'hff;
      end
      else if ((state == ospc_pkg::ST_DOUT) && !driving)
      begin
         driving <= 1'b1;
         dout_sh <= src_byte;
         rd_ptr <= ptr + 12'h001;
         hi_sel <= 1'b1;
      end
      else if (driving && sck_fall)
      begin
         if (quad)
         begin
            io_out <= {dout_sh[7:4], dout_sh[7:4]};
            io_oe_n_out <= 8'h00;
         end
         else
         begin
            io_out <= {2'h0, dout_sh[7], 3'h0, dout_sh[7], 1'b0};
            io_oe_n_out <= 8'hdd;
         end
         if ((obit + {1'b0, step}) == 4'h8)
         begin
            obit <= 4'h0;
            dout_sh <= src_byte;
            // past the end the pointer parks and OTP reads return ff
            if (!ptr[11])
               rd_ptr <= ptr + 12'h001;
            hi_sel <= !hi_sel;
         end
         else
         begin
            obit <= obit + {1'b0, step};
            dout_sh <= quad ? {dout_sh[3:0], 4'h0} :
               {dout_sh[6:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // byte programming checks
   assign pop_addr = pop_if.data[18:8];
   assign pop_byte = pop_if.data[7:0];
   assign pop_if.ready = (eng == ospc_pkg::ENG_OTP) && (tmr == 8'h00);
   assign pop_fire = pop_if.valid && pop_if.ready;
   assign zeros = (pop_byte != ospc_pkg::BYTE_ONES);
   assign locked_zero =
      otp_region_lock_in[pop_addr[10:ospc_pkg::REGION_LSB]] && zeros;
   assign unit = pop_addr[10:ospc_pkg::UNIT_LSB];
   assign rd_unit = rd_ptr[10:ospc_pkg::UNIT_LSB];

   // OTP cells only go from one to zero; start erased
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < ospc_pkg::OTP_BYTES; i++)
            otp_mem[i] <= ospc_pkg::BYTE_ONES;
      end
      else if (pop_fire && !locked_zero)
         otp_mem[pop_addr] <= otp_mem[pop_addr] & pop_byte;
   end

   ////////////////////////////////////////////////////////////////////
   // command commit at deselect and the self-timed write engine
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         eng <= ospc_pkg::ENG_IDLE;
         tmr <= 8'h00;
         write_enable_latch <= 1'b0;
         perr <= 1'b0;
         pcfg <= ospc_pkg::PCFG_RESET;
         dyn_lock <= {ospc_pkg::SECTORS{ospc_pkg::DYN_RESET}};
         unit_prog <= '0;
         unit_touch <= '0;
         ecc_off <= '0;
      end
      else
      begin
         case (eng)
            ospc_pkg::ENG_IDLE:
            begin
               if (cs_rise && (state == ospc_pkg::ST_SKIP) &&
                  (opcode == ospc_pkg::CMD_WRITE_ENABLE) &&
                  (din_bits == 5'h0))
                  write_enable_latch <= 1'b1;
               // without the latch nothing starts and progress stays low
               if (cs_rise && write_enable_latch && (state == ospc_pkg::ST_DIN))
               begin
                  case (opcode)
                     ospc_pkg::CMD_OTP_PROGRAM:
                     begin
                        if (din_bits >= ospc_pkg::BITS_ONE_BYTE)
                        begin
                           eng <= ospc_pkg::ENG_OTP;
                           perr <= ovf;
                           tmr <= 8'h00;
                        end
                     end
                     ospc_pkg::CMD_PCFG_PROGRAM:
                     begin
                        // any other bit count drops the command
                        if (din_bits == ospc_pkg::BITS_TWO_BYTES)
                        begin
                           pcfg <= pcfg_new;
                           perr <= 1'b0;
                           eng <= ospc_pkg::ENG_WAIT;
                           tmr <= ospc_pkg::PROG_CYC - 8'h01;
                        end
                     end
                     ospc_pkg::CMD_DYN_WRITE,
                     ospc_pkg::CMD_DYN_WRITE_WIDE:
                     begin
                        if ((din_bits == ospc_pkg::BITS_ONE_BYTE) &&
                           ((dyn_new == ospc_pkg::DYN_PROTECT) ||
                           (dyn_new == ospc_pkg::DYN_UNPROTECT)))
                        begin
                           dyn_lock[sector] <=
                              (dyn_new == ospc_pkg::DYN_PROTECT);
                           perr <= 1'b0;
                           eng <= ospc_pkg::ENG_WAIT;
                           tmr <= ospc_pkg::PROG_CYC - 8'h01;
                        end
                     end
                     default:
                        eng <= ospc_pkg::ENG_IDLE;
                  endcase
               end
            end
            ospc_pkg::ENG_OTP:
            begin
               if (pop_fire)
               begin
                  tmr <= ospc_pkg::OTP_BYTE_CYC - 8'h01;
                  if (locked_zero)
                     perr <= 1'b1;
                  else if (zeros)
                  begin
                     // earlier command touched it: correction off
                     if (unit_prog[unit])
                        ecc_off[unit] <= 1'b1;
                     unit_touch[unit] <= 1'b1;
                  end
               end
               else if (tmr != 8'h00)
                  tmr <= tmr - 8'h01;
               else if (!pop_if.valid)
               begin
                  unit_prog <= unit_prog | unit_touch;
                  unit_touch <= '0;
                  eng <= ospc_pkg::ENG_WAIT;
                  tmr <= ospc_pkg::PROG_CYC - 8'h01;
               end
            end
            ospc_pkg::ENG_WAIT:
            begin
               if (tmr == 8'h00)
               begin
                  eng <= ospc_pkg::ENG_IDLE;
                  write_enable_latch <= 1'b0;
               end
               else
                  tmr <= tmr - 8'h01;
            end
            default:
               eng <= ospc_pkg::ENG_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // status outputs
   assign op_in_progress_flag_out = (eng != ospc_pkg::ENG_IDLE);
   assign program_error_out = perr;
   assign write_enable_latch_out = write_enable_latch;
   assign protection_configuration_out = pcfg;
   assign otp_ecc_off_out = ecc_off[rd_unit];
endmodule : ospc_cmd
`default_nettype wire

// *** dv/ospc_host.sv ***
// host controller model: frames, serial clock and data pins
// assumes a 40 ns bench clock; one bit takes 8 clocks (320 ns)
`timescale 1ns/10ps
`default_nettype none
module ospc_host
(
   input wire logic clk_in,
   input wire logic [7:0] pin_in,
   output logic cs_n_out,
   output logic sck_out,
   output logic [7:0] io_out
);
   logic [31:0] rd;
   // clock parked low between frames, run at the 8x oversampling limit
   initial
   begin
      cs_n_out = 1'b1;
      sck_out = 1'b0;
      io_out = 8'h00;
   end
   // lines flip at each frame edge so no stale value lingers
   task sel(input logic on);
      repeat (8) @(negedge clk_in);
      cs_n_out = !on;
      io_out = ~io_out;
   endtask : sel
   // n bits of v, msb first; rd gathers io1 at each rise
   task xfer(input logic [31:0] v, input int n);
      rd = 32'h0;
      for (int i = n - 1; i >= 0; i--)
      begin
         io_out[0] = v[i];
         repeat (4) @(negedge clk_in);
         sck_out = 1'b1;
         rd = {rd[30:0], pin_in[1]};
         repeat (4) @(negedge clk_in);
         sck_out = 1'b0;
      end
   endtask : xfer
   // four-lane form: n nibbles of v, high first; rd gathers io3..io0
   task xfer4(input logic [31:0] v, input int n);
      rd = 32'h0;
      for (int i = n - 1; i >= 0; i--)
      begin
         io_out[3:0] = v[4*i +: 4];
         repeat (4) @(negedge clk_in);
         sck_out = 1'b1;
         rd = {rd[27:0], pin_in[3:0]};
         repeat (4) @(negedge clk_in);
         sck_out = 1'b0;
      end
   endtask : xfer4
endmodule : ospc_host
`default_nettype wire

// *** dv/ospc_cmd_sva.sv ***
// checker: flag and pin-enable relations of the command block
// assumes one clock, synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module ospc_cmd_sva
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic cs_n_in,
   input wire logic [7:0] io_oe_n_out,
   input wire logic op_in_progress_flag_out,
   input wire logic program_error_out,
   input wire logic write_enable_latch_out,
   input wire logic [15:0] protection_configuration_out
);
   // short aliases keep each property on few lines
   wire b = op_in_progress_flag_out;
   wire w = write_enable_latch_out;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence idle_s;
      cs_n_in [*8];
   endsequence
   ////////////////////////////////////////////////////////////
   idle_oe_a: assert property (idle_s |-> io_oe_n_out == 8'hff)
      else $error("oe idle");
   go_cs_a: assert property ($rose(b) |-> cs_n_in)
      else $error("start cs");
   go_wel_a: assert property ($rose(b) |-> w)
      else $error("start wel");
   busy_wel_a: assert property (b |-> w)
      else $error("busy wel");
   done_wel_a: assert property ($fell(b) |-> !w)
      else $error("done wel");
   wel_up_a: assert property ($rose(w) |-> !b)
      else $error("wel busy");
   cfg_busy_a: assert property ($changed(protection_configuration_out)
      |-> ##[0:1] b) else $error("cfg idle");
   perr_busy_a: assert property ($rose(program_error_out)
      |-> ##[0:1] b) else $error("perr idle");
endmodule : ospc_cmd_sva
bind ospc_cmd ospc_cmd_sva chk (.*);
`default_nettype wire

// *** dv/ospc_cmd_tb_top.sv ***
// bench for the OTP and sector protection command block
// assumes the host model on the pins and the checker bound to uut
`timescale 1ns/10ps
`default_nettype none
module ospc_cmd_tb_top;
   logic clk_in, rst_in, cs_n, sck, busy, perr, write_enable_latch;
   logic [7:0] io_h, io_d, oe_n;
   logic quad, wide, ecc;
   logic [3:0] lock, lat;
   logic [15:0] pcfg;
   // low enable bit hands the pin to the device
   wire [7:0] pin = (~oe_n & io_d) | (oe_n & io_h);
   int n_errors = 0;
   int n_checks = 0;
   ospc_host host (.clk_in, .pin_in(pin), .cs_n_out(cs_n), .sck_out(sck),
      .io_out(io_h));
   ospc_cmd uut (.clk_in, .rst_in, .cs_n_in(cs_n), .sck_in(sck),
      .io_in(pin), .io_out(io_d), .io_oe_n_out(oe_n),
      .four_lane_command_mode_in(quad), .addr_wide_in(wide),
      .read_latency_in(lat), .otp_region_lock_in(lock),
      .op_in_progress_flag_out(busy), .program_error_out(perr),
      .write_enable_latch_out(write_enable_latch), .protection_configuration_out(pcfg),
      .otp_ecc_off_out(ecc));
   ////////////////////////////////////////////////////////////
   task summarize;
      if (n_errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] seen, input logic [31:0] exp, string what);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // bounded wait for a self-timed write to end
   task idle;
      repeat (8) @(negedge clk_in);
      for (int k = 0; k < 3000 && busy !== 1'b0; k++)
         @(negedge clk_in);
      if (busy !== 1'b0)
      begin
         chk(busy, 1'b0, "busy");
         summarize();
      end
   endtask : idle
   task frame(input logic [31:0] a, int na, logic [31:0] d, int nd);
      host.sel(1'b1);
      host.xfer(a, na);
      if (nd > 0)
         host.xfer(d, nd);
      host.sel(1'b0);
   endtask : frame
   // latch set first, then the write frame
   task wr(input logic [31:0] a, int na, logic [31:0] d, int nd);
      frame(32'h06, 8, 32'h0, 0);
      frame(a, na, d, nd);
      idle();
   endtask : wr
   ////////////////////////////////////////////////////////////
   // config: refused without latch, then programmed and read twice
   task sc_pcfg;
      frame(32'h2f, 8, 32'h3412, 16);
      idle();
      chk(pcfg, 16'hffff, "pcfg unlatched");
      wr(32'h2f, 8, 32'h34, 8);
      chk(pcfg, 16'hffff, "pcfg short");
      wr(32'h2f, 8, 32'h3412, 16);
      chk({pcfg, write_enable_latch}, {16'h1234, 1'b0}, "pcfg");
      frame(32'h2b, 8, 32'h0, 32);
      chk(host.rd, 32'h34123412, "pcfg read");
   endtask : sc_pcfg
   // sector lock: read twice, protect, read with the wide form
   task sc_dyn;
      frame(32'hfa080000, 32, 32'h0, 16);
      chk(host.rd, 32'hffff, "lock twice");
      wr(32'hfb080000, 32, 32'h00, 8);
      chk(write_enable_latch, 1'b0, "lock wel");
      // last address byte rides in the data pass; low 16 bits are the reply
      frame(32'he0000800, 32, 32'h0, 24);
      chk(host.rd[15:0], 16'h0000, "locked");
      wide = 1'b1;
      frame(32'hfa000800, 32, 32'h0, 24);
      chk(host.rd[15:0], 16'h0000, "wide lock");
      wide = 1'b0;
   endtask : sc_dyn
   // four-lane read of the protected sector; host lanes idle high
   task sc_quad;
      quad = 1'b1;
      host.sel(1'b1);
      host.xfer4(32'hfa080000, 8);
      host.xfer4(32'hffffffff, 4);
      host.sel(1'b0);
      chk(host.rd[15:0], 16'h0000, "quad lock");
      quad = 1'b0;
   endtask : sc_quad
   // otp: program twice, latency read, ones then zeros into lock
   task sc_otp;
      wr(32'h42000010, 32, 32'h5a, 8);
      wr(32'h42000010, 32, 32'hf0, 8);
      // read pointer sits in the twice-programmed unit before deselect
      host.sel(1'b1);
      host.xfer(32'h4b000010, 32);
      host.xfer(32'h0, 18);
      chk(ecc, 1'b1, "ecc off");
      host.sel(1'b0);
      chk(host.rd[15:0], 16'h50ff, "otp read");
      lat = 4'h0;
      frame(32'h4b000010, 32, 32'h0, 16);
      chk(host.rd[15:0], 16'h50ff, "otp no latency");
      lock = 4'h1;
      wr(32'h42000020, 32, 32'hff, 8);
      chk(perr, 1'b0, "ones locked");
      wr(32'h42000020, 32, 32'h0f, 8);
      chk(perr, 1'b1, "zeros locked");
   endtask : sc_otp
   initial
   begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   // reset for two clocks, then each scenario
   initial
   begin
      rst_in = 1'b1;
      lock = 4'h0;
      quad = 1'b0;
      wide = 1'b0;
      lat = 4'h2;
      // count rising edges: the first clock change at time zero is a fall
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      rst_in = 1'b0;
      sc_pcfg();
      sc_dyn();
      sc_quad();
      sc_otp();
      summarize();
   end
endmodule : ospc_cmd_tb_top
`default_nettype wire
